/* File: verilog/fps_pkg.sv */
// Purpose: constants for the flash program/erase sequencer
// Assumes: 50 MHz pclk, apb slave with 32-bit data
// Notes:   registers are word aligned, upper data bits read zero
// Behaviour
// - key 0x55 then 0xaa, uninterrupted, arms the start bit
// - setting bit 15 of flash_op_control after unlock launches operation
// - value 0x4003 erases one page at the target address
// - value 0x4002 programs one row from the latches
// - value 0x4001 programs two instruction words from the latches
// - value 0x4000 writes one configuration register from latch zero
// - table writes fill latches; programming copies latches into flash
// - a row uses 128 latches, each loaded by low and high writes
// - double word programming uses two latches
// - latches are reached with table page 0xfa, offset from zero
// - target address bit 23 selects configuration space
// - configuration registers ignore upper eight bits
// - configuration registers rewrite without prior erase
// - target address split: high holds page, low holds offset
// - device times operation, stalls core, clears start when done
// - power reset aborts at once; other resets wait for completion
package fps_pkg;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_ADDR_HI  = 8'h04;
  localparam logic [7:0]  OFS_ADDR_LO  = 8'h08;
  localparam logic [7:0]  OFS_KEY      = 8'h0c;
  localparam logic [7:0]  OFS_TBL_PAGE = 8'h10;
  localparam logic [7:0]  OFS_TBL_OFS  = 8'h14;
  localparam logic [7:0]  OFS_TBL_LOW  = 8'h18;
  localparam logic [7:0]  OFS_TBL_HIGH = 8'h1c;
  localparam logic [7:0]  OFS_STATUS   = 8'h20;
  localparam logic [7:0]  KEY_FIRST    = 8'h55;
  localparam logic [7:0]  KEY_SECOND   = 8'haa;
  localparam int          START_BIT    = 15;
  localparam int          CFG_SPACE_BIT = 23;
  localparam logic [3:0]  OP_CFG_WRITE = 4'h0;
  localparam logic [3:0]  OP_DWORD     = 4'h1;
  localparam logic [3:0]  OP_ROW       = 4'h2;
  localparam logic [3:0]  OP_ERASE     = 4'h3;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [7:0]  LATCH_PAGE   = 8'hfa;
  localparam int          ROW_WORDS    = 128;
  localparam int          CLK_MHZ      = 50;
  localparam int          ERASE_US     = 20;
  localparam int          PROG_US      = 2;
  localparam int          ERASE_CYC    = ERASE_US * CLK_MHZ;
  localparam int          PROG_CYC     = PROG_US * CLK_MHZ;
  typedef enum logic [1:0] {
    FPS_IDLE = 2'b00,
    FPS_PREP = 2'b01,
    FPS_BUSY = 2'b11,
    FPS_DONE = 2'b10
  } fps_state_t;
endpackage : fps_pkg

/* File: verilog/fps_flash_if.sv */
// Purpose: link from sequencer to flash array
// Assumes: one clock, array answers with a done pulse
// Notes:   words are 24 bits, address carries the space bit
`timescale 1ns/1ps
`default_nettype none
interface fps_flash_if;
  logic        req;
  logic        erase;
  logic [23:0] addr;
  logic [23:0] wdata;
  logic        done;
  modport seq   (output req, output erase, output addr, output wdata,
                 input done);
  modport array (input req, input erase, input addr, input wdata,
                 output done);
endinterface : fps_flash_if
`default_nettype wire

/* File: verilog/fps_latch_mem.sv */
// Purpose: write latch storage, 24-bit words
// Assumes: one write and one registered read port
// Notes:   low and high halves written separately
`timescale 1ns/1ps
`default_nettype none
module fps_latch_mem #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          pclk,
  input  wire logic [AW-1:0] waddr,
  input  wire logic          we_low,
  input  wire logic          we_high,
  input  wire logic [15:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [23:0]   rdata_ff
);
  logic [23:0] mem [DEPTH];
  always_ff @(posedge pclk)
  begin
    if (we_low)
      mem[waddr][15:0] <= wdata;
    if (we_high)
      mem[waddr][23:16] <= wdata[7:0];
    rdata_ff <= mem[raddr];
  end
endmodule : fps_latch_mem
`default_nettype wire

/* File: verilog/fps_flash_seq.sv */
// Purpose: self_programming sequencer, apb registers and flash link
// Assumes: apb master holds request until pready; zero wait states
// Notes:   cpu_stall is high while an operation runs
`timescale 1ns/1ps
`default_nettype none
module fps_flash_seq #(
  parameter int ROW_WORDS  = fps_pkg::ROW_WORDS,
  parameter int ERASE_CYC  = fps_pkg::ERASE_CYC,
  parameter int PROG_CYC   = fps_pkg::PROG_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sys_reset_req,
  output logic             sys_reset_go,
  output logic             cpu_stall,
  output logic             flash_req,
  output logic             flash_erase,
  output logic      [23:0] flash_addr,
  output logic      [23:0] flash_wdata,
  input  wire logic        flash_done
);
  localparam int AW = $clog2(ROW_WORDS);
  // space bit as seen in the page half of the target address
  localparam int CFG_BIT = fps_pkg::CFG_SPACE_BIT - 16;
  fps_flash_if fl ();
  logic             wr_acc;
  logic             rd_acc;
  logic [7:0]       ofs;
  logic [15:0]      ctrl_ff;
  logic [7:0]       addr_hi_ff;
  logic [15:0]      addr_lo_ff;
  logic [7:0]       tbl_page_ff;
  logic [15:0]      tbl_ofs_ff;
  logic [1:0]       key_ff;
  logic [1:0]       nxt_key;
  logic             armed;
  logic             start;
  fps_pkg::fps_state_t st_ff;
  logic [AW:0]      idx_ff;
  logic [AW:0]      nwords;
  logic [31:0]      cnt_ff;
  logic             tbl_hit;
  logic [AW-1:0]    lat_waddr;
  logic [23:0]      lat_rdata;
  logic             rst_pend_ff;
  logic [31:0]      nxt_rdata;
  logic             reg_we;
  logic             bad_addr;
  logic [31:0]      op_cyc;
  logic             word_end;
  logic             last_word;
  logic [AW-1:0]    lat_raddr;

  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign ofs     = paddr[7:0];
  assign pready  = 1'b1;
  assign bad_addr = paddr[31:8] != 24'h0 || ofs > fps_pkg::OFS_STATUS
                    || ofs[1:0] != 2'b00;
  assign pslverr = psel & penable & bad_addr;
  // register and latch writes, except key writes, are refused while an operation runs
  assign reg_we  = wr_acc && st_ff == fps_pkg::FPS_IDLE;
  // latches only reachable through the dedicated table page
  assign tbl_hit = tbl_page_ff == fps_pkg::LATCH_PAGE;
  assign lat_waddr = tbl_ofs_ff[AW:1];
  assign armed   = key_ff == 2'd2;
  assign start   = wr_acc && ofs == fps_pkg::OFS_CTRL
                   && pwdata[fps_pkg::START_BIT] && armed
                   && st_ff == fps_pkg::FPS_IDLE;

  // key tracker: any write not in sequence disarms
  always_comb
  begin
    nxt_key = key_ff;
    if (wr_acc)
    begin
      if (ofs == fps_pkg::OFS_KEY && pwdata[7:0] == fps_pkg::KEY_FIRST)
        nxt_key = 2'd1;
      else if (ofs == fps_pkg::OFS_KEY && key_ff == 2'd1
               && pwdata[7:0] == fps_pkg::KEY_SECOND)
        nxt_key = 2'd2;
      else
        nxt_key = 2'd0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      key_ff <= 2'd0;
    else
      key_ff <= nxt_key;
  end

  // operation select is locked while busy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= fps_pkg::CTRL_RESET;
    else if (st_ff == fps_pkg::FPS_DONE)
      ctrl_ff[fps_pkg::START_BIT] <= 1'b0;
    else if (st_ff == fps_pkg::FPS_IDLE && wr_acc
             && ofs == fps_pkg::OFS_CTRL)
    begin
      ctrl_ff[14:0] <= pwdata[14:0];
      ctrl_ff[fps_pkg::START_BIT] <= start;
    end
  end

  // page half of the target address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addr_hi_ff <= 8'h00;
    else if (reg_we && ofs == fps_pkg::OFS_ADDR_HI)
      addr_hi_ff <= pwdata[7:0];
  end

  // offset half of the target address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addr_lo_ff <= 16'h0000;
    else if (reg_we && ofs == fps_pkg::OFS_ADDR_LO)
      addr_lo_ff <= pwdata[15:0];
  end

  // table page: only one value opens the latches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tbl_page_ff <= 8'h00;
    else if (reg_we && ofs == fps_pkg::OFS_TBL_PAGE)
      tbl_page_ff <= pwdata[7:0];
  end

  // table offset, in byte units, two per latch word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tbl_ofs_ff <= 16'h0000;
    else if (reg_we && ofs == fps_pkg::OFS_TBL_OFS)
      tbl_ofs_ff <= pwdata[15:0];
  end

  // number of latch words for the selected operation
  always_comb
  begin
    case (ctrl_ff[3:0])
      fps_pkg::OP_ROW:   nwords = (AW+1)'(ROW_WORDS);
      fps_pkg::OP_DWORD: nwords = (AW+1)'(2);
      default:           nwords = (AW+1)'(1);
    endcase
  end

  // per-word timeout only guards against a lost done pulse
  assign op_cyc    = (ctrl_ff[3:0] == fps_pkg::OP_ERASE) ? 32'(ERASE_CYC)
                                                        : 32'(PROG_CYC);
  assign word_end  = fl.done || cnt_ff == op_cyc;
  assign last_word = ctrl_ff[3:0] == fps_pkg::OP_ERASE
                     || idx_ff + (AW+1)'(1) == nwords;

  // sequencer: one flash request per latch word, erase uses one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= fps_pkg::FPS_IDLE;
    else
    begin
      case (st_ff)
        fps_pkg::FPS_IDLE:
          if (start)
            st_ff <= fps_pkg::FPS_PREP;
        fps_pkg::FPS_PREP:
          st_ff <= fps_pkg::FPS_BUSY;
        fps_pkg::FPS_BUSY:
          if (word_end && last_word)
            st_ff <= fps_pkg::FPS_DONE;
          else if (word_end)
            st_ff <= fps_pkg::FPS_PREP;
        fps_pkg::FPS_DONE:
          st_ff <= fps_pkg::FPS_IDLE;
        default:
          st_ff <= fps_pkg::FPS_IDLE;
      endcase
    end
  end

  // word index into the latches, cleared at every start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idx_ff <= '0;
    else if (start)
      idx_ff <= '0;
    else if (st_ff == fps_pkg::FPS_BUSY && word_end && !last_word)
      idx_ff <= idx_ff + (AW+1)'(1);
  end

  // cycle counter of the word in flight
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= 32'h0;
    else if (st_ff == fps_pkg::FPS_PREP)
      cnt_ff <= 32'h0;
    else if (st_ff == fps_pkg::FPS_BUSY)
      cnt_ff <= cnt_ff + 32'h1;
  end

  // read one word ahead: latch data are registered, so the word
  // must be on its way before the request goes out
  always_comb
  begin
    lat_raddr = idx_ff[AW-1:0];
    if (st_ff == fps_pkg::FPS_IDLE)
      lat_raddr = '0;
    else if (st_ff == fps_pkg::FPS_BUSY)
      lat_raddr = idx_ff[AW-1:0] + AW'(1);
  end

  // request is a one-cycle pulse out of the prep state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fl.req <= 1'b0;
    else
      fl.req <= st_ff == fps_pkg::FPS_PREP;
  end

  // erase needs one request and no latch data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fl.erase <= 1'b0;
    else
      fl.erase <= ctrl_ff[3:0] == fps_pkg::OP_ERASE;
  end

  // word index steps by two in offset units
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fl.addr <= 24'h0;
    else
      fl.addr <= {addr_hi_ff, addr_lo_ff} + 24'({idx_ff, 1'b0});
  end

  // configuration words have no upper byte, forced to zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fl.wdata <= 24'h0;
    else if (ctrl_ff[3:0] == fps_pkg::OP_CFG_WRITE
             && addr_hi_ff[CFG_BIT])
      fl.wdata <= {8'h00, lat_rdata[15:0]};
    else
      fl.wdata <= lat_rdata;
  end

  assign fl.done     = flash_done;
  assign flash_req   = fl.req;
  assign flash_erase = fl.erase;
  assign flash_addr  = fl.addr;
  assign flash_wdata = fl.wdata;
  assign cpu_stall   = st_ff != fps_pkg::FPS_IDLE;

  // non-power resets held until the operation ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_pend_ff <= 1'b0;
    else if (sys_reset_req)
      rst_pend_ff <= 1'b1; // request wins, a held request keeps go high
    else if (st_ff == fps_pkg::FPS_IDLE)
      rst_pend_ff <= 1'b0;
  end
  assign sys_reset_go = rst_pend_ff && st_ff == fps_pkg::FPS_IDLE;

  fps_latch_mem #(.DEPTH(ROW_WORDS), .AW(AW)) u_latch (
    .pclk    (pclk),
    .waddr   (lat_waddr),
    .we_low  (reg_we && ofs == fps_pkg::OFS_TBL_LOW && tbl_hit),
    .we_high (reg_we && ofs == fps_pkg::OFS_TBL_HIGH && tbl_hit),
    .wdata   (pwdata[15:0]),
    .raddr   (lat_raddr),
    .rdata_ff(lat_rdata)
  );

  always_comb
  begin
    case (ofs)
      fps_pkg::OFS_CTRL:     nxt_rdata = {16'h0, ctrl_ff};
      fps_pkg::OFS_ADDR_HI:  nxt_rdata = {24'h0, addr_hi_ff};
      fps_pkg::OFS_ADDR_LO:  nxt_rdata = {16'h0, addr_lo_ff};
      fps_pkg::OFS_TBL_PAGE: nxt_rdata = {24'h0, tbl_page_ff};
      fps_pkg::OFS_TBL_OFS:  nxt_rdata = {16'h0, tbl_ofs_ff};
      fps_pkg::OFS_STATUS:   nxt_rdata = {29'h0, armed, st_ff != fps_pkg::FPS_IDLE,
                                          rst_pend_ff};
      default:               nxt_rdata = 32'h0;
    endcase
  end
  assign prdata = rd_acc ? nxt_rdata : 32'h0;
endmodule : fps_flash_seq
`default_nettype wire

/* File: verif/fps_flash_seq_properties.sv */
// Purpose: port assertions for the flash sequencer
// Assumes: one pclk domain, async presetn
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module fps_flash_seq_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sys_reset_req,
  input wire logic        sys_reset_go,
  input wire logic        cpu_stall,
  input wire logic        flash_req,
  input wire logic        flash_erase,
  input wire logic [23:0] flash_addr,
  input wire logic [23:0] flash_wdata,
  input wire logic        flash_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        wr_start;
  logic [11:0] stall_cnt_ff;
  assign wr_start = psel && penable && pwrite && pwdata[15] &&
                    paddr[7:0] == fps_pkg::OFS_CTRL;
  // long stalls mean the sequencer lost its done or timeout
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      stall_cnt_ff <= 12'h000;
    else
      stall_cnt_ff <= cpu_stall ? stall_cnt_ff + 12'h001 : 12'h000;
  sequence s_erase_req;
    flash_req && flash_erase;
  endsequence
  sequence s_reset_wait;
    sys_reset_req && !cpu_stall;
  endsequence
  property p_start;
    $rose(cpu_stall) |-> $past(wr_start, 1) || $past(wr_start, 2);
  endproperty
  a_start: assert property (p_start)
    else $error("operation began without a start write");
  property p_req_pulse;
    flash_req |=> !flash_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("flash request longer than one cycle");
  property p_req_in_op;
    flash_req |-> cpu_stall;
  endproperty
  a_req_in_op: assert property (p_req_in_op)
    else $error("flash request outside an operation");
  property p_bounded;
    stall_cnt_ff < 12'h800;
  endproperty
  a_bounded: assert property (p_bounded)
    else $error("operation never finished");
  property p_erase_one;
    s_erase_req |=> !flash_req [*8];
  endproperty
  a_erase_one: assert property (p_erase_one)
    else $error("erase issued more than one request");
  property p_cfg_mask;
    flash_req && flash_addr[23] |-> flash_wdata[23:16] == 8'h00;
  endproperty
  a_cfg_mask: assert property (p_cfg_mask)
    else $error("configuration upper byte not ignored");
  property p_go_safe;
    sys_reset_go |-> !cpu_stall;
  endproperty
  a_go_safe: assert property (p_go_safe)
    else $error("reset released during an operation");
  property p_go_when;
    s_reset_wait |-> ##[0:2] (sys_reset_go || cpu_stall);
  endproperty
  a_go_when: assert property (p_go_when)
    else $error("pending reset not released when idle");
endmodule : fps_flash_seq_properties
`default_nettype wire

/* File: verif/fps_flash_model.sv */
// Purpose: flash array stand-in, logs every request
// Assumes: one request at a time
// Notes:   slow makes done late but inside the timeout
`timescale 1ns/1ps
`default_nettype none
module fps_flash_model (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        req,
  input wire logic        erase,
  input wire logic [23:0] addr,
  input wire logic [23:0] wdata,
  input wire logic        slow,
  output logic            done
);
  logic [23:0] q_addr[$];
  logic [23:0] q_data[$];
  logic        q_erase[$];
  int          cnt;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt  <= 0;
      done <= 1'b0;
    end
    else if (req)
    begin
      q_addr.push_back(addr);
      q_data.push_back(wdata);
      q_erase.push_back(erase);
      cnt  <= slow ? 6 : 2;
      done <= 1'b0;
    end
    else
    begin
      cnt  <= (cnt != 0) ? cnt - 1 : 0;
      done <= (cnt == 1);
    end
endmodule : fps_flash_model
`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: apb driven checks of the flash sequencer
// Assumes: zero wait state slave, short op timers
// Notes:   the array model logs requests for comparison
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        sys_reset_req = 0, slow = 0, pready, pslverr, sys_reset_go;
  logic        cpu_stall, flash_req, flash_erase, flash_done;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic [23:0] flash_addr, flash_wdata;
  int          err_total = 0, comparisons = 0, b;
  always #10 pclk = ~pclk;
  fps_flash_seq #(.ERASE_CYC(8), .PROG_CYC(8)) i_fps_flash_seq (.*);
  fps_flash_model i_fps_flash_model (.clk(pclk), .rst_n(presetn),
    .req(flash_req), .erase(flash_erase), .addr(flash_addr),
    .wdata(flash_wdata), .slow(slow), .done(flash_done));
  task automatic finish_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, a > fps_pkg::OFS_STATUS});
  endtask : rd
  task automatic load(input logic [7:0] i, input logic [23:0] w);
    wr(fps_pkg::OFS_TBL_OFS, {23'h0, i, 1'b0});
    wr(fps_pkg::OFS_TBL_LOW, {16'h0, w[15:0]});
    wr(fps_pkg::OFS_TBL_HIGH, {24'h0, w[23:16]});
  endtask : load
  task automatic start(input logic [3:0] op, input logic [23:0] ad);
    b = i_fps_flash_model.q_addr.size();
    wr(fps_pkg::OFS_CTRL, {28'h0400, op});
    wr(fps_pkg::OFS_ADDR_HI, {24'h0, ad[23:16]});
    wr(fps_pkg::OFS_ADDR_LO, {16'h0, ad[15:0]});
    wr(fps_pkg::OFS_KEY, 32'h55);
    wr(fps_pkg::OFS_KEY, 32'haa);
    rd(fps_pkg::OFS_STATUS, 32'h4);
    wr(fps_pkg::OFS_CTRL, {28'h0c00, op});
    repeat (2) @(posedge pclk);
  endtask : start
  task automatic run(input logic [3:0] op, input logic [23:0] ad);
    int i;
    start(op, ad);
    i = 0;
    while (cpu_stall !== 1'b0 && i < 3000)
    begin
      @(posedge pclk);
      i++;
    end
    rd(fps_pkg::OFS_CTRL, {28'h0400, op});
  endtask : run
  task automatic got(input int n, input logic [23:0] a, input logic [23:0] d);
    chk(i_fps_flash_model.q_addr[b+n], {8'h0, a});
    chk(i_fps_flash_model.q_data[b+n], {8'h0, d});
  endtask : got
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(fps_pkg::OFS_CTRL, 32'h0);
    rd(fps_pkg::OFS_ADDR_HI, 32'h0);
    rd(8'h24, 32'h0);
    wr(fps_pkg::OFS_CTRL, 32'hc003);
    wr(fps_pkg::OFS_KEY, 32'haa);
    wr(fps_pkg::OFS_KEY, 32'h55);
    wr(fps_pkg::OFS_CTRL, 32'hc003);
    wr(fps_pkg::OFS_KEY, 32'h55);
    wr(fps_pkg::OFS_KEY, 32'haa);
    wr(fps_pkg::OFS_ADDR_LO, 32'h0);
    wr(fps_pkg::OFS_CTRL, 32'hc003);
    rd(fps_pkg::OFS_CTRL, 32'h4003);
    chk(i_fps_flash_model.q_addr.size(), 0);
    run(fps_pkg::OP_ERASE, 24'h022000);
    chk(i_fps_flash_model.q_addr.size() - b, 1);
    chk({31'h0, i_fps_flash_model.q_erase[b]}, 32'h1);
    got(0, 24'h022000, i_fps_flash_model.q_data[b]);
    wr(fps_pkg::OFS_TBL_PAGE, 32'hfa);
    load(8'h00, 24'h561234);
    load(8'h01, 24'hde9abc);
    run(fps_pkg::OP_DWORD, 24'h022000);
    chk(i_fps_flash_model.q_addr.size() - b, 2);
    got(0, 24'h022000, 24'h561234);
    got(1, 24'h022002, 24'hde9abc);
    slow <= 1'b1;
    for (int i = 0; i < 128; i++)
      load(i[7:0], {8'ha5, i[7:0], ~i[7:0]});
    start(fps_pkg::OP_ROW, 24'h030000);
    sys_reset_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, sys_reset_go}, 32'h0);
    while (cpu_stall !== 1'b0) @(posedge pclk);
    repeat (3) @(posedge pclk);
    chk({31'h0, sys_reset_go}, 32'h1);
    sys_reset_req <= 1'b0;
    chk(i_fps_flash_model.q_addr.size() - b, 128);
    for (int i = 0; i < 128; i++)
      got(i, 24'h030000 + 24'(2 * i), {8'ha5, i[7:0], ~i[7:0]});
    slow <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      load(8'h00, k == 0 ? 24'h77abcd : 24'h001357);
      // pclk stands for internal_fast_rc in this bench
      run(fps_pkg::OP_CFG_WRITE, 24'hf80000);
      got(0, 24'hf80000, k == 0 ? 24'h00abcd : 24'h001357);
    end
    start(fps_pkg::OP_ROW, 24'h040000);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({30'h0, cpu_stall, flash_req}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(fps_pkg::OFS_CTRL, 32'h0);
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : testbench
bind fps_flash_seq fps_flash_seq_properties i_fps_flash_seq_properties (.*);
`default_nettype wire
